// ---- core/clock_fanout_select_gate.sv ----
/*
 * reference clock select, glitch-free output gate and tenfold fanout.
 * assumes the reference clocks are slow against core_clk, which samples
 * them as plain pins; outputs are the sampled clock, one flop per leg.
 */
// What this block does
// - select 0 (default) routes hstl reference, select 1 routes pecl.
// - the chosen clock drives ten identical differential output pairs.
// - disable at 0 (default) lets every output pair follow the clock.
// - disable at 1 holds true outputs low and complements high.
// - disable is synchronised to the chosen clock before it gates.
// - outputs change between enabled and disabled only while true is low.
// - disable may change at any time; no runt pulse results.
`timescale 1ns/10ps
module clock_fanout_select_gate (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // reference clock pairs
    input wire logic hstlRefInP,
    input wire logic hstlRefInN,
    input wire logic peclRefInP,
    input wire logic peclRefInN,
    // static controls
    input wire logic refInputSelect,
    input wire logic outputDisable,
    // fanout pairs
    output logic [fanout_pkg::FANOUT_COUNT-1:0] fanoutOutP,
    output logic [fanout_pkg::FANOUT_COUNT-1:0] fanoutOutN
);
    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    // a pair with both legs equal reads as low, so a dead input is quiet
    logic [fanout_pkg::PIN_COUNT-1:0] pinRaw;
    logic [fanout_pkg::PIN_COUNT-1:0] syncA;
    logic [fanout_pkg::PIN_COUNT-1:0] syncB;
    logic [fanout_pkg::PIN_COUNT-1:0] syncC;
    logic [fanout_pkg::PIN_COUNT-1:0] pinLvl;
    logic [fanout_pkg::PIN_COUNT-1:0] next_pinLvl;
    logic [fanout_pkg::PIN_COUNT-1:0] next_syncA;
    logic [fanout_pkg::PIN_COUNT-1:0] next_syncB;
    logic [fanout_pkg::PIN_COUNT-1:0] next_syncC;

    assign pinRaw = {outputDisable, refInputSelect,
                     peclRefInP & ~peclRefInN, hstlRefInP & ~hstlRefInN};

    always_comb begin
        next_syncA = pinRaw;
        next_syncB = syncA;
        next_syncC = syncB;
        for (int i = 0; i < fanout_pkg::PIN_COUNT; i++) begin
            next_pinLvl[i] = (syncB[i] == syncC[i]) ? syncC[i] : pinLvl[i];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA <= fanout_pkg::SYNC_RESET;
            syncB <= fanout_pkg::SYNC_RESET;
            syncC <= fanout_pkg::SYNC_RESET;
            pinLvl <= fanout_pkg::SYNC_RESET;
        end else if (clkEn) begin
            syncA <= next_syncA;
            syncB <= next_syncB;
            syncC <= next_syncC;
            pinLvl <= next_pinLvl;
        end
    end

    sync_chain_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        clkEn |=> (syncB == $past(syncA) && syncC == $past(syncB)))
        else $error("synchroniser stage skipped");

    // a level only moves once the last two stages agree on it
    pin_filter_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        ((pinLvl ^ $past(pinLvl)) &
         (($past(syncB) ^ $past(syncC)) | (pinLvl ^ $past(syncC)))) == '0)
        else $error("pin level taken before stages agree");

    // ----------------------------------------
    // clock select
    // ----------------------------------------
    logic chosen;
    logic disLvl;

    assign chosen = pinLvl[fanout_pkg::PIN_SEL] ?
                    pinLvl[fanout_pkg::PIN_PECL] :
                    pinLvl[fanout_pkg::PIN_HSTL];
    assign disLvl = pinLvl[fanout_pkg::PIN_DIS];

    // ----------------------------------------
    // output gate
    // ----------------------------------------
    // the gate only moves while the chosen clock is low, so the next
    // high phase is either passed whole or suppressed whole
    logic gate;
    logic next_gate;
    logic [fanout_pkg::FANOUT_COUNT-1:0] next_fanoutOutP;
    logic [fanout_pkg::FANOUT_COUNT-1:0] next_fanoutOutN;

    always_comb begin
        next_gate = gate;
        if (!chosen) begin
            next_gate = !disLvl;
        end
        next_fanoutOutP = {fanout_pkg::FANOUT_COUNT{next_gate & chosen}};
        next_fanoutOutN = ~next_fanoutOutP;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            gate <= fanout_pkg::GATE_RESET;
            fanoutOutP <= fanout_pkg::TRUE_RESET;
            fanoutOutN <= fanout_pkg::COMP_RESET;
        end else if (clkEn) begin
            gate <= next_gate;
            fanoutOutP <= next_fanoutOutP;
            fanoutOutN <= next_fanoutOutN;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    select_route_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (clkEn && gate && !disLvl && pinLvl[fanout_pkg::PIN_SEL])
        |=> fanoutOutP[0] == $past(pinLvl[fanout_pkg::PIN_PECL]))
        else $error("pecl reference not routed");

    pairs_identical_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        fanoutOutP == {fanout_pkg::FANOUT_COUNT{fanoutOutP[0]}})
        else $error("output pairs differ");

    enabled_follow_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (clkEn && gate && !disLvl) |=> fanoutOutP[0] == $past(chosen))
        else $error("enabled output does not follow clock");

    disabled_low_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        fanoutOutN == ~fanoutOutP and ((clkEn && !gate) |=> !fanoutOutP[0]))
        else $error("disabled output not held low");

    disable_sync_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (clkEn && disLvl && !chosen) |=> !gate)
        else $error("disable not taken while clock low");

    switch_low_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        $changed(gate) |-> (fanoutOutP == '0 && !$past(chosen)))
        else $error("gate moved while clock high");

    no_runt_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (clkEn && chosen) |=> $stable(gate))
        else $error("gate moved during high phase");

    select_hstl_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (clkEn && gate && !disLvl && !pinLvl[fanout_pkg::PIN_SEL])
        |=> fanoutOutP[0] == $past(pinLvl[fanout_pkg::PIN_HSTL]))
        else $error("hstl reference not routed");

    pairs_complement_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        fanoutOutN == {fanout_pkg::FANOUT_COUNT{fanoutOutN[0]}})
        else $error("complement pairs differ");

    enable_sync_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (clkEn && !disLvl && !chosen) |=> gate)
        else $error("enable not taken while clock low");

    enabled_hold_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (clkEn && gate && !disLvl) |=> gate)
        else $error("enabled gate closed");

    disabled_hold_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        (clkEn && !gate && disLvl) |=> !gate)
        else $error("disabled gate reopened");

    gate_park_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !gate |-> (fanoutOutP == '0 && fanoutOutN == '1))
        else $error("closed gate left outputs active");

    // ----------------------------------------
    // pulse shape
    // ----------------------------------------
    // an output edge must line up with an edge of the chosen source,
    // so no pulse is ever shorter than the source's own high phase
    pulse_start_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        ($rose(fanoutOutP[0]) && $past(clkEn) && $past(clkEn, 2))
        |-> ($past(chosen) && !$past(chosen, 2)))
        else $error("output pulse began inside a source high phase");

    pulse_end_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        ($fell(fanoutOutP[0]) && $past(clkEn)) |-> !$past(chosen))
        else $error("output pulse cut inside a source high phase");

    // ----------------------------------------
    // reset and clock enable
    // ----------------------------------------
    reset_default_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        $rose(arst_n) |-> (gate && fanoutOutP == '0 && fanoutOutN == '1))
        else $error("reset left outputs active or gate closed");

    // pins are not sampled while frozen, so a short pin pulse can be missed
    enable_freeze_a: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !clkEn |=> ($stable(syncA) && $stable(syncB) && $stable(syncC) &&
            $stable(pinLvl) && $stable(gate) && $stable(fanoutOutP)))
        else $error("state moved while clock enable low");
endmodule

// ---- core/fanout_pkg.sv ----
/*
 * constants shared by the reference clock fanout gate.
 * assumes nothing beyond a single sampling clock in the user.
 */
package fanout_pkg;
    // ----------------------------------------
    // structure
    // ----------------------------------------
    localparam int FANOUT_COUNT = 10;
    localparam int SYNC_DEPTH = 3;
    localparam int PIN_COUNT = 4;
    // ----------------------------------------
    // pin indices into the input synchroniser
    // ----------------------------------------
    localparam int PIN_HSTL = 0;
    localparam int PIN_PECL = 1;
    localparam int PIN_SEL = 2;
    localparam int PIN_DIS = 3;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [PIN_COUNT-1:0] SYNC_RESET = 4'h0;
    localparam logic GATE_RESET = 1'b1;
    localparam logic [FANOUT_COUNT-1:0] TRUE_RESET = 10'h000;
    localparam logic [FANOUT_COUNT-1:0] COMP_RESET = 10'h3ff;
endpackage

// ---- sim/ref_clock_source.sv ----
/* free-running reference clock pairs for the fanout gate.
   assumes core_clk runs free; periods are whole core_clk cycles. */
`timescale 1ns/10ps
module ref_clock_source #(
    parameter int HALF_HSTL = 8,
    parameter int HALF_PECL = 20
) (
    // sampling clock
    input wire logic core_clk,
    // reference pairs
    output logic hstlP,
    output logic hstlN,
    output logic peclP,
    output logic peclN
);
    int hc = 0;
    int pc = 0;
    initial begin
        hstlP = 1'b0;
        peclP = 1'b0;
    end
    // clocks run free, so edges land at every phase of the disable control
    always @(posedge core_clk) begin
        hc <= (hc == HALF_HSTL - 1) ? 0 : hc + 1;
        pc <= (pc == HALF_PECL - 1) ? 0 : pc + 1;
        if (hc == HALF_HSTL - 1) hstlP <= ~hstlP;
        if (pc == HALF_PECL - 1) peclP <= ~peclP;
    end
    assign hstlN = ~hstlP;
    assign peclN = ~peclP;
endmodule

// ---- sim/tb_clock_fanout_select_gate.sv ----
/* self-checking bench for the fanout gate.
   assumes the reference model above drives both clock pairs. */
`timescale 1ns/10ps
module tb_clock_fanout_select_gate;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic sel = 1'b0;
    logic dis = 1'b0;
    logic en = 1'b1;
    logic hP, hN, pP, pN;
    logic [9:0] outP, outN;
    int err_count = 0;
    int samples_checked = 0;
    typedef struct {logic s; logic d; int half; logic [9:0] rises;} row_t;
    row_t rows[4] = '{'{0, 0, 8, 10}, '{1, 0, 20, 4}, '{0, 1, 8, 0},
                      '{1, 1, 20, 0}};
    initial forever #25 core_clk = ~core_clk;
    ref_clock_source u_ref_clock_source(.core_clk(core_clk), .hstlP(hP),
        .hstlN(hN), .peclP(pP), .peclN(pN));
    clock_fanout_select_gate u_clock_fanout_select_gate(.core_clk(core_clk),
        .arst_n(arst_n), .clkEn(en), .hstlRefInP(hP), .hstlRefInN(hN),
        .peclRefInP(pP), .peclRefInN(pN), .refInputSelect(sel),
        .outputDisable(dis), .fanoutOutP(outP), .fanoutOutN(outN));
    task check(logic [9:0] seen, logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // a pulse is judged only if it starts inside the window
    task run(int n, int half, logic [9:0] expRises);
        int hi;
        logic [9:0] rises;
        logic started, prev;
        hi = 0;
        rises = 0;
        started = 0;
        @(negedge core_clk);
        prev = outP[0];
        repeat (n) begin
            @(negedge core_clk);
            check(outN, ~outP);
            check(outP, {10{outP[0]}});
            if (outP[0] === 1'b1 && prev !== 1'b1) begin
                rises++;
                started = 1;
                hi = 0;
            end
            if (outP[0] === 1'b1) hi++;
            if (outP[0] !== 1'b1 && prev === 1'b1 && started)
                check(hi[9:0], half[9:0]);
            prev = outP[0];
        end
        if (expRises !== 10'h3ff) check(rises, expRises);
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        check(outN, 10'h3ff);
        check(outP, 10'h000);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            sel <= rows[i].s;
            dis <= rows[i].d;
            repeat (80) @(posedge core_clk);
            run(160, rows[i].half, rows[i].rises);
        end
        sel <= 1'b0;
        dis <= 1'b0;
        repeat (80) @(posedge core_clk);
        fork
            run(400, 8, 10'h3ff);
            repeat (9) begin
                repeat (37) @(posedge core_clk);
                dis <= ~dis;
            end
        join
        @(posedge core_clk);
        dis <= 1'b0;
        repeat (80) @(posedge core_clk);
        // frozen while running: the freeze check in the design watches
        en <= 1'b0;
        repeat (20) @(posedge core_clk);
        en <= 1'b1;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b0;
        @(negedge core_clk);
        check(outP, 10'h000);
        check(outN, 10'h3ff);
        end_sim;
    end
    initial begin
        #200000;
        err_count++;
        end_sim;
    end
endmodule
